// File: dv/wmc_properties.sv
// Checker: bus handshakes, watchdog spacing, power flag
`timescale 1ns/1ps
`default_nettype none
module wmc_properties #(
    parameter int WD_BASE = 8
) (
    // Clock and resets
    input wire logic        clock_in,
    input wire logic        rst_in,
    input wire logic        por_in,
    // Bus handshakes
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    input wire logic [1:0]  s_axi_bresp_out,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in,
    input wire logic [31:0] s_axi_rdata_out,
    // Watched outputs
    input wire logic        power_loss_flag_out,
    input wire logic        wd_reset_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // Cycles since last expiry; restarts only lengthen it
    logic [31:0] gap_ff;
    logic        seen_ff;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            gap_ff  <= 32'h0000_0000;
            seen_ff <= 1'b0;
        end else begin
            gap_ff  <= wd_reset_out ? 32'h0000_0001 : gap_ff + 32'h0000_0001;
            seen_ff <= seen_ff | wd_reset_out;
        end
    end

    // Write and read takes
    sequence wr_take_s;
        s_axi_awvalid_in && s_axi_awready_out
            && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence rd_take_s;
        s_axi_arvalid_in && s_axi_arready_out;
    endsequence

    write_answer_a:
        assert property (wr_take_s |-> ##[1:2] s_axi_bvalid_out)
        else $error("write response missing");
    read_answer_a:
        assert property (rd_take_s |-> ##[1:2] s_axi_rvalid_out)
        else $error("read response missing");
    bresp_hold_a:
        assert property (s_axi_bvalid_out && !s_axi_bready_in
            |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped early");
    rdata_hold_a:
        assert property (s_axi_rvalid_out && !s_axi_rready_in
            |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped early");
    upper_zero_a:
        assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
        else $error("upper read bits not zero");
    flag_set_a:
        assert property ($fell(por_in) |-> ##[0:2] power_loss_flag_out)
        else $error("power-up did not set flag");
    flag_hold_a:
        assert property (!por_in && !$past(por_in) && !$past(por_in, 2)
            && !$past(rst_in) && !$past(rst_in, 2)
            && !$past(s_axi_bvalid_out) && !$past(s_axi_bvalid_out, 2)
            |-> $stable(power_loss_flag_out))
        else $error("flag changed without a write");
    wd_gap_a:
        assert property (wd_reset_out && seen_ff |-> gap_ff >= WD_BASE)
        else $error("watchdog expired too soon");
endmodule : wmc_properties
`default_nettype wire

// File: dv/wmc_top_test.sv
// Testbench for the watchdog/memory control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module wmc_top_test;
    localparam logic [1:0] OK = wmc_pkg::RESP_OKAY;
    localparam logic [1:0] ER = wmc_pkg::RESP_SLVERR;
    localparam logic [7:0] CT = wmc_pkg::IDX_WMCTRL;
    localparam logic [7:0] ST = wmc_pkg::IDX_IRQ_STAT;
    localparam logic [7:0] PW = wmc_pkg::IDX_PWR_CTRL;
    localparam logic [7:0] P0 = wmc_pkg::IDX_PTR0_LO;
    // Bench-driven inputs
    logic        clock_in = 1'b0, rst_in = 1'b1, por_in = 1'b1;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, ptr_upd = 1'b0, busy = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [15:0] ptr_val = 16'h0000;
    // Design outputs
    logic        awready, wready, bvalid, arready, rvalid, both_rdy;
    logic        ee_acc, ee_wr, flag, wd_rst, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] act_ptr;
    // Bookkeeping and reference model
    int          error_cnt = 0, n_checks = 0, wd_cnt = 0, wn = 0;
    integer      seed = 32'h2E2C17BD;
    logic [15:0] pm [2];
    logic [7:0]  stat_m = 8'h00;

    assign both_rdy = awready & wready;
    always #50 clock_in = ~clock_in;
    // Expiry pulses, counted where settled
    always @(negedge clock_in) if (wd_rst === 1'b1) wd_cnt++;

    wmc_top #(.WD_BASE(8)) wmc_top_i (
        .clock_in(clock_in), .rst_in(rst_in), .por_in(por_in),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .ptr_update_in(ptr_upd),
        .ptr_value_in(ptr_val), .eeprom_busy_in(busy),
        .active_pointer_out(act_ptr), .eeprom_access_enable_out(ee_acc),
        .eeprom_write_enable_out(ee_wr), .power_loss_flag_out(flag),
        .wd_reset_out(wd_rst), .irq_out(irq));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test

    // Bounded poll on falling edges; wn counts them
    task automatic await(ref logic s);
        wn = 0;
        do begin
            @(negedge clock_in);
            wn++;
        end while (s !== 1'b1 && wn < 2000);
        if (wn >= 2000) begin
            error_cnt++;
            stop_test();
        end
    endtask : await

    // Late ready, so the answer must stand
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      input logic [1:0] er);
        @(posedge clock_in);
        awaddr  <= {2'h0, idx, 2'h0};
        wdata   <= {24'($random(seed)), d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        await(both_rdy);
        @(posedge clock_in);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        repeat (2) @(posedge clock_in);
        bready <= 1'b1;
        await(bvalid);
        `CHK(bresp, er)
        @(posedge clock_in);
        bready <= 1'b0;
    endtask : wr

    task automatic rchk(input logic [7:0] idx, input logic [7:0] e,
                        input logic [1:0] er);
        @(posedge clock_in);
        araddr  <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        await(arready);
        @(posedge clock_in);
        arvalid <= 1'b0;
        repeat (2) @(posedge clock_in);
        rready <= 1'b1;
        await(rvalid);
        `CHK(rdata, {24'h0, e})
        `CHK(rresp, er)
        @(posedge clock_in);
        rready <= 1'b0;
    endtask : rchk

    // Main sequence
    initial begin
        int pc;
        repeat (2) @(posedge clock_in);
        por_in <= 1'b0;
        repeat (8) @(posedge clock_in);
        rst_in <= 1'b0;
        rchk(CT, 8'h02, OK);
        rchk(PW, 8'h10, OK);
        rchk(8'hC0, 8'h00, ER);
        wr(8'hC0, 8'h55, ER);
        $display("done: reset and map");
        for (int b = 0; b < 2; b++) begin
            pm[b] = 16'($random(seed));
            wr(8'(P0 + 2 * b), pm[b][7:0], OK);
            wr(8'(P0 + 2 * b + 1), pm[b][15:8], OK);
        end
        // Core update goes to the selected bank only
        for (int b = 0; b < 2; b++) begin
            wr(CT, {5'h00, 1'(b), 2'h0}, OK);
            repeat (2) @(negedge clock_in);
            `CHK(act_ptr, pm[b])
            @(posedge clock_in);
            ptr_upd <= 1'b1;
            ptr_val <= 16'($random(seed));
            @(posedge clock_in);
            ptr_upd <= 1'b0;
            pm[b] = ptr_val;
            repeat (2) @(negedge clock_in);
            `CHK(act_ptr, pm[b])
        end
        for (int b = 0; b < 2; b++) begin
            rchk(8'(P0 + 2 * b), pm[b][7:0], OK);
            rchk(8'(P0 + 2 * b + 1), pm[b][15:8], OK);
        end
        $display("done: pointer banks");
        wr(CT, 8'h18, OK);
        repeat (2) @(negedge clock_in);
        `CHK({ee_acc, ee_wr}, 2'h3)
        wr(wmc_pkg::IDX_IRQ_MASK, 8'h02, OK);
        @(posedge clock_in);
        busy <= 1'b1;
        rchk(CT, 8'h18, OK);
        @(posedge clock_in);
        busy <= 1'b0;
        stat_m = 8'h02;
        repeat (3) @(negedge clock_in);
        `CHK(irq, 1'b1)
        rchk(CT, 8'h1A, OK);
        rchk(ST, stat_m, OK);
        repeat (3) @(negedge clock_in);
        `CHK(irq, 1'b0)
        wr(CT, 8'h10, OK);
        repeat (2) @(negedge clock_in);
        `CHK({ee_acc, ee_wr}, 2'h1)
        wr(wmc_pkg::IDX_IRQ_MASK, 8'h01, OK);
        $display("done: eeprom steering");
        // Period per prescaler code, expiry to expiry
        for (int ps = 0; ps < 8; ps++) begin
            wr(CT, {3'(ps), 5'h03}, OK);
            await(wd_rst);
            await(wd_rst);
            `CHK(wn >= (8 << ps) && wn <= (8 << ps) + 1, 1'b1)
        end
        stat_m = 8'h01;
        repeat (3) @(negedge clock_in);
        `CHK(irq, 1'b1)
        pc = wd_cnt;
        repeat (8) wr(CT, 8'h43, OK);
        `CHK(wd_cnt, pc)
        @(posedge clock_in);
        busy <= 1'b1;
        rchk(CT, 8'h41, OK);
        wr(CT, 8'h40, OK);
        busy <= 1'b0;
        stat_m = 8'h03;
        pc = wd_cnt;
        repeat (300) @(posedge clock_in);
        `CHK(wd_cnt, pc)
        rchk(ST, stat_m, OK);
        repeat (3) @(negedge clock_in);
        `CHK(irq, 1'b0)
        rchk(ST, 8'h00, OK);
        $display("done: watchdog");
        wr(PW, 8'h00, OK);
        repeat (2) @(negedge clock_in);
        `CHK(flag, 1'b0)
        @(posedge clock_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
        rchk(PW, 8'h00, OK);
        rchk(8'(P0 + 3), 8'h00, OK);
        wr(PW, 8'h10, OK);
        rchk(PW, 8'h10, OK);
        wr(PW, 8'h00, OK);
        @(posedge clock_in);
        por_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        por_in <= 1'b0;
        repeat (2) @(negedge clock_in);
        `CHK(flag, 1'b1)
        $display("done: power flag");
        stop_test();
    end
endmodule : wmc_top_test

bind wmc_top wmc_properties #(.WD_BASE(WD_BASE)) wmc_properties_i (
    .clock_in, .rst_in, .por_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out,
    .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in,
    .s_axi_rdata_out, .power_loss_flag_out, .wd_reset_out);
`default_nettype wire

// File: rtl/wmc_pkg.sv
// Package: register map, field layout and timing for the watchdog/memory block
package wmc_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_PTR0_LO   = 8'h82;
    localparam logic [7:0] IDX_PTR0_HI   = 8'h83;
    localparam logic [7:0] IDX_PTR1_LO   = 8'h84;
    localparam logic [7:0] IDX_PTR1_HI   = 8'h85;
    localparam logic [7:0] IDX_PWR_CTRL  = 8'h87;
    localparam logic [7:0] IDX_WMCTRL    = 8'h96;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'hA0;
    localparam logic [7:0] IDX_IRQ_MASK  = 8'hA1;

    // Reset values
    localparam logic [7:0]  WMCTRL_RST   = 8'h02;
    localparam logic [15:0] PTR_RST      = 16'h0000;
    localparam logic [1:0]  IRQ_RST      = 2'h0;

    // Field positions
    localparam int PWR_LOSS_BIT    = 4;
    localparam int RESTART_BIT     = 1;
    localparam int IRQ_WD_BIT      = 0;
    localparam int IRQ_EE_BIT      = 1;
    localparam int IRQ_W           = 2;
    localparam int PRESCALE_MAX    = 7;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing: core clock rate and shortest watchdog period
    localparam int CLK_HZ          = 10_000_000;
    localparam int WD_BASE_MS      = 16;
    localparam int WD_BASE_CYCLES  = (CLK_HZ / 1000) * WD_BASE_MS;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic [2:0] prescale;
        logic       eeprom_write_enable;
        logic       eeprom_access_enable;
        logic       pointer_bank_select;
        logic       wd_restart;
        logic       wd_enable;
    } wmc_ctrl_t;

endpackage : wmc_pkg

// File: rtl/wmc_top.sv
// Watchdog, EEPROM steering, dual pointer and power flag block
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE_01 - Two 16-bit pointer banks at 82H and 84H
// RULE_02 - Select bit zero uses bank zero, one bank one
// RULE_03 - Software sets select bit before pointer access
// RULE_04 - Power-loss flag bit 4, set at power-up
// RULE_05 - Software sets/clears flag; device reset ignores it (power_loss_flag_out is still cleared while rst_in is high)
// RULE_06 - Prescaler zero gives 16 ms, seven 2048 ms
// RULE_07 - Watchdog runs only while enable bit is one
// RULE_08 - Writing restart one pulses watchdog counter clear
// RULE_09 - Restart bit self-clears next cycle
// RULE_10 - Bit 1 write restarts, read gives ready
// RULE_11 - Ready flag reads one when EEPROM accepts
// RULE_12 - Ready zero while programming, returns one after
// RULE_13 - Access enable steers moves to EEPROM or external
// RULE_14 - Software sets write enable before EEPROM write
// RULE_15 - Software clears write enable after write
// RULE_16 - Control register at 96H with fixed layout
// RULE_17 - Each prescaler step doubles the period
// RULE_18 - Expired enabled watchdog asserts internal reset
module wmc_top #(
    parameter int ADDR_W    = 12,
    parameter int WD_BASE   = wmc_pkg::WD_BASE_CYCLES,
    parameter int WD_CNT_W  = 25
) (
    // Clock, device reset and power-on reset
    input  wire logic              clock_in,
    input  wire logic              rst_in,
    input  wire logic              por_in,
    // AXI4-Lite write address and data
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    // AXI4-Lite write response
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    output logic [1:0]             s_axi_bresp_out,
    // AXI4-Lite read
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    // Pointer datapath update from the core
    input  wire logic              ptr_update_in,
    input  wire logic [15:0]       ptr_value_in,
    // EEPROM programming engine status
    input  wire logic              eeprom_busy_in,
    // Steering and control outputs
    output logic [15:0]            active_pointer_out,
    output logic                   eeprom_access_enable_out,
    output logic                   eeprom_write_enable_out,
    output logic                   power_loss_flag_out,
    // Watchdog reset request and interrupt
    output logic                   wd_reset_out,
    output logic                   irq_out
);

    // Elaboration checks on the parameters
    initial begin
        if (WD_BASE < 1) begin
            $error("wmc_top: WD_BASE must be at least one cycle");
        end
        if ((longint'(WD_BASE) << wmc_pkg::PRESCALE_MAX) >
            (longint'(1) << WD_CNT_W)) begin
            $error("wmc_top: WD_CNT_W too small for longest period");
        end
        if (ADDR_W < 10) begin
            $error("wmc_top: ADDR_W too small for the register map");
        end
    end

    // Hit when a byte address selects the given register index
    function automatic logic idx_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [7:0] idx);
        idx_hit = (addr[1:0] == 2'h0) &&
                  (addr[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, idx});
    endfunction : idx_hit

    // Watchdog limit for a prescaler code: base doubled per step
    function automatic logic [WD_CNT_W-1:0] wd_limit(input logic [2:0] ps);
        logic [WD_CNT_W-1:0] base;
        base = WD_CNT_W'(WD_BASE);
        wd_limit = base << ps; // [RULE_06] [RULE_17]
    endfunction : wd_limit

    // Register state
    wmc_pkg::wmc_ctrl_t      ctrl_ff;
    logic [15:0]             ptr0_ff;
    logic [15:0]             ptr1_ff;
    logic                    pwr_loss_ff;
    logic [wmc_pkg::IRQ_W-1:0] irq_stat_ff;
    logic [wmc_pkg::IRQ_W-1:0] irq_mask_ff;

    // Bus state
    logic                    aw_held_ff;
    logic                    w_held_ff;
    logic [ADDR_W-1:0]       aw_addr_ff;
    logic [7:0]              w_byte_ff;
    logic                    w_lane0_ff;

    // Watchdog and EEPROM tracking
    logic [WD_CNT_W-1:0]     wd_cnt_ff;
    logic                    restart_pulse_ff;
    logic                    busy_prev_ff;

    // Decoded write, read and event signals
    logic                    wr_go;
    logic                    wr_en;
    logic                    wr_mapped;
    logic                    rd_go;
    logic                    rd_mapped;
    logic [7:0]              rd_byte;
    logic                    ctrl_wr;
    logic                    wd_expire;
    logic                    ee_done;
    logic                    stat_rd_clr;
    wmc_pkg::wmc_ctrl_t      ctrl_view;

    // A write commits once both address and data are held
    assign wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid_out;
    assign wr_en = wr_go && w_lane0_ff;
    assign rd_go = s_axi_arvalid_in && s_axi_arready_out;

    // Write address decode
    always_comb begin
        wr_mapped = idx_hit(aw_addr_ff, wmc_pkg::IDX_PTR0_LO)
                 || idx_hit(aw_addr_ff, wmc_pkg::IDX_PTR0_HI)
                 || idx_hit(aw_addr_ff, wmc_pkg::IDX_PTR1_LO)
                 || idx_hit(aw_addr_ff, wmc_pkg::IDX_PTR1_HI)
                 || idx_hit(aw_addr_ff, wmc_pkg::IDX_PWR_CTRL)
                 || idx_hit(aw_addr_ff, wmc_pkg::IDX_WMCTRL)
                 || idx_hit(aw_addr_ff, wmc_pkg::IDX_IRQ_STAT)
                 || idx_hit(aw_addr_ff, wmc_pkg::IDX_IRQ_MASK);
    end

    assign ctrl_wr = wr_en && idx_hit(aw_addr_ff, wmc_pkg::IDX_WMCTRL);

    // Control register view: bit 1 shows ready, never the restart write
    always_comb begin
        ctrl_view = ctrl_ff;
        ctrl_view.wd_restart = !eeprom_busy_in; // [RULE_10] [RULE_11] [RULE_12]
    end

    // Read mux; unmapped indices give an error and zero
    always_comb begin
        rd_byte   = 8'h00;
        rd_mapped = 1'b1;
        if (idx_hit(s_axi_araddr_in, wmc_pkg::IDX_PTR0_LO)) begin
            rd_byte = ptr0_ff[7:0];
        end else if (idx_hit(s_axi_araddr_in, wmc_pkg::IDX_PTR0_HI)) begin
            rd_byte = ptr0_ff[15:8];
        end else if (idx_hit(s_axi_araddr_in, wmc_pkg::IDX_PTR1_LO)) begin
            rd_byte = ptr1_ff[7:0];
        end else if (idx_hit(s_axi_araddr_in, wmc_pkg::IDX_PTR1_HI)) begin
            rd_byte = ptr1_ff[15:8];
        end else if (idx_hit(s_axi_araddr_in, wmc_pkg::IDX_PWR_CTRL)) begin
            rd_byte[wmc_pkg::PWR_LOSS_BIT] = pwr_loss_ff;
        end else if (idx_hit(s_axi_araddr_in, wmc_pkg::IDX_WMCTRL)) begin
            rd_byte = ctrl_view; // [RULE_16]
        end else if (idx_hit(s_axi_araddr_in, wmc_pkg::IDX_IRQ_STAT)) begin
            rd_byte[wmc_pkg::IRQ_W-1:0] = irq_stat_ff;
        end else if (idx_hit(s_axi_araddr_in, wmc_pkg::IDX_IRQ_MASK)) begin
            rd_byte[wmc_pkg::IRQ_W-1:0] = irq_mask_ff;
        end else begin
            rd_mapped = 1'b0;
        end
    end

    assign stat_rd_clr = rd_go && idx_hit(s_axi_araddr_in,
                                          wmc_pkg::IDX_IRQ_STAT);

    // Write channels, taken in either order
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            aw_held_ff        <= 1'b0;
            w_held_ff         <= 1'b0;
            aw_addr_ff        <= '0;
            w_byte_ff         <= 8'h00;
            w_lane0_ff        <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_held_ff        <= 1'b1;
                aw_addr_ff        <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_held_ff        <= 1'b1;
                w_byte_ff        <= s_axi_wdata_in[7:0];
                w_lane0_ff       <= s_axi_wstrb_in[0];
                s_axi_wready_out <= 1'b0;
            end
            // Reopen both channels only after the response is taken
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                aw_held_ff        <= 1'b0;
                w_held_ff         <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out  <= 1'b1;
            end
        end
    end

    // Write response
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= wmc_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= wr_mapped ? wmc_pkg::RESP_OKAY
                                          : wmc_pkg::RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // Read channel: one read outstanding, data captured at address accept
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= wmc_pkg::RESP_OKAY;
        end else if (rd_go) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rdata_out   <= {24'h00_0000, rd_byte};
            s_axi_rresp_out   <= rd_mapped ? wmc_pkg::RESP_OKAY
                                           : wmc_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out  <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end
    end

    // Control register; the restart bit is always stored as one, never as written
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_ff <= wmc_pkg::WMCTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_ff            <= w_byte_ff; // [RULE_16]
            ctrl_ff.wd_restart <= 1'b1;      // [RULE_09]
        end
    end

    // Restart pulse lasts exactly one cycle per write of one
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            restart_pulse_ff <= 1'b0;
        end else begin
            restart_pulse_ff <= ctrl_wr &&
                w_byte_ff[wmc_pkg::RESTART_BIT]; // [RULE_08] [RULE_09]
        end
    end

    // Pointer banks: software bytes win over a core update
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ptr0_ff <= wmc_pkg::PTR_RST;
            ptr1_ff <= wmc_pkg::PTR_RST;
        end else begin
            if (ptr_update_in) begin
                if (ctrl_ff.pointer_bank_select) begin // [RULE_02]
                    ptr1_ff <= ptr_value_in;
                end else begin
                    ptr0_ff <= ptr_value_in;
                end
            end
            if (wr_en && idx_hit(aw_addr_ff, wmc_pkg::IDX_PTR0_LO)) begin
                ptr0_ff[7:0] <= w_byte_ff; // [RULE_01]
            end
            if (wr_en && idx_hit(aw_addr_ff, wmc_pkg::IDX_PTR0_HI)) begin
                ptr0_ff[15:8] <= w_byte_ff;
            end
            if (wr_en && idx_hit(aw_addr_ff, wmc_pkg::IDX_PTR1_LO)) begin
                ptr1_ff[7:0] <= w_byte_ff; // [RULE_01]
            end
            if (wr_en && idx_hit(aw_addr_ff, wmc_pkg::IDX_PTR1_HI)) begin
                ptr1_ff[15:8] <= w_byte_ff;
            end
        end
    end

    // Active pointer follows the select bit one cycle later
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            active_pointer_out <= wmc_pkg::PTR_RST;
        end else begin
            active_pointer_out <= ctrl_ff.pointer_bank_select
                                  ? ptr1_ff : ptr0_ff; // [RULE_02]
        end
    end

    // Power-loss flag: power-on or a write of one sets it, device reset leaves it
    always_ff @(posedge clock_in or posedge por_in) begin
        if (por_in) begin
            pwr_loss_ff <= 1'b1; // [RULE_04]
        end else if (wr_en && idx_hit(aw_addr_ff, wmc_pkg::IDX_PWR_CTRL)) begin
            pwr_loss_ff <= w_byte_ff[wmc_pkg::PWR_LOSS_BIT]; // [RULE_05]
        end
    end

    // Registered power flag and EEPROM steering bits
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            eeprom_access_enable_out <= 1'b0;
            eeprom_write_enable_out  <= 1'b0;
            power_loss_flag_out      <= 1'b0;
        end else begin
            eeprom_access_enable_out <= ctrl_ff.eeprom_access_enable; // [RULE_13]
            eeprom_write_enable_out  <= ctrl_ff.eeprom_write_enable;
            power_loss_flag_out      <= pwr_loss_ff;
        end
    end

    // Watchdog expiry: enabled counter reaches the limit minus one with no restart
    assign wd_expire = ctrl_ff.wd_enable && !restart_pulse_ff &&
                       (wd_cnt_ff >= wd_limit(ctrl_ff.prescale) - 1'b1);

    // Watchdog counter; disabled or restarted means back to zero
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wd_cnt_ff <= '0;
        end else if (!ctrl_ff.wd_enable || restart_pulse_ff) begin
            wd_cnt_ff <= '0; // [RULE_07] [RULE_08]
        end else if (wd_expire) begin
            wd_cnt_ff <= '0;
        end else begin
            wd_cnt_ff <= wd_cnt_ff + 1'b1; // [RULE_07]
        end
    end

    // Internal reset request, one cycle wide
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wd_reset_out <= 1'b0;
        end else begin
            wd_reset_out <= wd_expire; // [RULE_18]
        end
    end

    // Programming end is the falling edge of the busy input
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            busy_prev_ff <= 1'b0;
        end else begin
            busy_prev_ff <= eeprom_busy_in;
        end
    end

    assign ee_done = busy_prev_ff && !eeprom_busy_in; // [RULE_12]

    // Sticky status; an event beats a same-cycle read clear
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_stat_ff <= wmc_pkg::IRQ_RST;
        end else begin
            for (int i = 0; i < wmc_pkg::IRQ_W; i++) begin
                if (stat_rd_clr) begin
                    irq_stat_ff[i] <= 1'b0;
                end
            end
            if (wd_expire) begin
                irq_stat_ff[wmc_pkg::IRQ_WD_BIT] <= 1'b1;
            end
            if (ee_done) begin
                irq_stat_ff[wmc_pkg::IRQ_EE_BIT] <= 1'b1;
            end
        end
    end

    // Mask register; one enables the matching status bit
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_mask_ff <= wmc_pkg::IRQ_RST;
        end else if (wr_en && idx_hit(aw_addr_ff, wmc_pkg::IDX_IRQ_MASK)) begin
            irq_mask_ff <= w_byte_ff[wmc_pkg::IRQ_W-1:0];
        end
    end

    // Level interrupt from a flop
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat_ff & irq_mask_ff);
        end
    end

endmodule : wmc_top

`default_nettype wire
